// ==== src/term_pkg.sv ====
package term_pkg;
   // Terminal and key counts
   localparam int NUM_TERM = 3;
   localparam int NUM_KEY = 4;
   localparam int THERM_TERM = 2;
   localparam int KEY_RUN = 0;
   localparam int KEY_STOP = 1;
   localparam int KEY_PRG = 2;
   localparam int KEY_MON = 3;

   // Input function codes
   localparam logic [7:0] FN_FWD = 8'h00;
   localparam logic [7:0] FN_EXT = 8'h0C;
   localparam logic [7:0] FN_ANALOG_SEL = 8'h10;
   localparam logic [7:0] FN_THERM = 8'h13;
   localparam logic [7:0] FN_START = 8'h14;
   localparam logic [7:0] FN_STOP = 8'h15;
   localparam logic [7:0] FN_DIR = 8'h16;
   localparam logic [7:0] FN_NET = 8'h19;
   localparam logic [7:0] FN_UP = 8'h1B;
   localparam logic [7:0] FN_DOWN = 8'h1C;
   localparam logic [7:0] FN_FORCE_OP = 8'h1F;
   localparam logic [7:0] FN_LAST = 8'h1F;

   // Reset values
   localparam logic [7:0] FUNC1_RST = FN_FWD;
   localparam logic [7:0] FUNC2_RST = FN_STOP;
   localparam logic [7:0] FUNC3_RST = FN_EXT;
   localparam logic [7:0] POL_NO = 8'h00;
   localparam logic [7:0] POL_NC = 8'h01;
   localparam logic [7:0] POL_RST = POL_NO;
   localparam logic [15:0] SPEED_RST = 16'h0000;

   // Parameter store selects
   localparam logic [3:0] SEL_FUNC1 = 4'h0;
   localparam logic [3:0] SEL_POL1 = 4'h3;
   localparam logic [3:0] SEL_ACCEL = 4'h6;
   localparam logic [3:0] SEL_DECEL = 4'h7;
   localparam logic [3:0] SEL_SPEED = 4'h8;
   localparam logic [3:0] SEL_STATUS = 4'h9;

   // Timing and speed scale (frequency in 0.1 Hz units)
   localparam int CLK_HZ = 10_000_000;
   localparam int RAMP_UNIT_MS = 100;
   localparam int RAMP_DEF_S = 10;
   localparam logic [7:0] RAMP_RST = 8'(RAMP_DEF_S * 1000 / RAMP_UNIT_MS);
   localparam int TICK_CYC = CLK_HZ / 1000 * RAMP_UNIT_MS;
   localparam logic [15:0] FREQ_FULL = 16'h0258;
   localparam logic [15:0] NEAR_STOP = 16'h0005;

   typedef enum logic [1:0] {DS_STOP, DS_RUN, DS_TRIP} drive_state_t;
   typedef logic [NUM_TERM-1:0][7:0] code_arr_t;

   // Code accepted for a terminal
   function automatic logic func_legal(input logic [7:0] code, input int term);
      return (code <= FN_LAST) && (code != FN_ANALOG_SEL)
         && ((code != FN_THERM) || (term == THERM_TERM));
   endfunction

   // Any terminal assigned to function f that is asserted in act
   function automatic logic fn_hit(input code_arr_t codes, input logic [NUM_TERM-1:0] act,
                                   input logic [7:0] f);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_TERM; i++) begin
         hit = hit | (act[i] && (codes[i] == f));
      end
      return hit;
   endfunction
endpackage

// ==== src/ramp_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ramp_if;
   logic [15:0] target;
   logic [15:0] freq;
   logic [7:0] rate;
   modport ctl (output target, output rate, input freq);
   modport gen (input target, input rate, output freq);
endinterface
`default_nettype wire

// ==== src/term_sense.sv ====
`timescale 1ns/1ps
`default_nettype none
module term_sense #(
   parameter int N = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [N-1:0] pin,
   input wire logic [N-1:0] invert,
   output logic [N-1:0] level,
   output logic [N-1:0] rise,
   output logic [N-1:0] fall
);
   logic [N-1:0] s1_r;
   logic [N-1:0] s2_r;
   logic [N-1:0] act;

   if (N < 1) begin : g_chk
      $error("term_sense needs at least one input");
   end

   // Two-stage synchroniser; only the second stage is looked at
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
      end else if (ce) begin
         s1_r <= pin;
         s2_r <= s1_r;
      end
   end

   assign act = s2_r ^ invert;

   // Polarity applied before edges, so with invert set a closed contact opening reads as a rise
   always_ff @(posedge clk) begin
      if (rst) begin
         level <= '0;
         rise <= '0;
         fall <= '0;
      end else if (ce) begin
         level <= act;
         rise <= act & ~level;
         fall <= ~act & level;
      end
   end
endmodule // term_sense
`default_nettype wire

// ==== src/ramp_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module ramp_gen #(
   parameter int TICK = 1_000_000,
   parameter logic [15:0] FULL = 16'h0258
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   ramp_if.gen rp
);
   logic [39:0] acc_r;
   logic [39:0] limit;
   logic [39:0] sum;
   logic [7:0] rate_eff;

   if (TICK < 1 || FULL == 16'h0000) begin : g_chk
      $error("ramp_gen needs a nonzero tick and full scale");
   end

   // Zero ramp time would step every cycle; treat it as the shortest ramp
   assign rate_eff = (rp.rate == 8'h00) ? 8'h01 : rp.rate;
   assign limit = 40'(rate_eff) * 40'(TICK);
   assign sum = acc_r + 40'(FULL);

   // Full scale is covered in rate*TICK cycles, one step at most per cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_r <= '0;
         rp.freq <= 16'h0000;
      end else if (ce) begin
         if (rp.freq == rp.target) begin
            acc_r <= '0;
         end else if (sum >= limit) begin
            acc_r <= sum - limit;
            rp.freq <= (rp.target > rp.freq) ? rp.freq + 16'h0001 : rp.freq - 16'h0001;
         end else begin
            acc_r <= sum;
         end
      end
   end
endmodule // ramp_gen
`default_nettype wire

// ==== src/term_map_top.sv ====
// Behaviour
// - Three input terminals, each assigned a function by stored code 00 to 31.
// - Terminal three may also take code 19, thermistor protection input.
// - Reset codes: terminal one 00, terminal two 21, terminal three 12.
// - Per-terminal polarity: 00 normally open, 01 normally closed inverting level.
// - All three polarity codes reset to normally open.
// - Code 20 start, 21 stop, 22 forward/reverse select.
// - Code 27 speed increase, code 28 speed decrease.
// - Code 25 network select, code 31 forced panel operation.
// - Code 16, analog source select, is refused.
// - Program indicator lit in program mode, dark in monitor mode.
// - Run/stop and program/monitor states are independent of each other.
// - Pressing the monitor key leaves program mode at once.
// - Acceleration and deceleration times reset to ten seconds.
// - Drive outputs switch off once speed reaches near stop at zero command.
// - Enabled run key starts and lights run; stop key stops the motor.
// - Network control while network select is active, local control otherwise.
// - Start input active edge starts with acceleration; inactive does nothing.
`timescale 1ns/1ps
`default_nettype none
module term_map_top
   import term_pkg::*;
#(
   parameter int TICK = term_pkg::TICK_CYC,
   parameter logic [15:0] FULL = term_pkg::FREQ_FULL
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [term_pkg::NUM_TERM-1:0] TERM_IN,
   input wire logic [term_pkg::NUM_KEY-1:0] KEY_IN,
   input wire logic RUN_KEY_EN,
   input wire logic STORE_STB,
   input wire logic [3:0] PARAM_SEL,
   input wire logic [15:0] PARAM_DATA,
   input wire logic NET_RUN,
   input wire logic NET_STOP,
   input wire logic NET_REV,
   input wire logic [15:0] NET_SPEED,
   output logic [15:0] PARAM_Q,
   output logic STORE_REJ,
   output logic RUN_LED,
   output logic PROG_LED,
   output logic DRIVE_ON,
   output logic [15:0] FREQ_OUT,
   output logic REVERSE,
   output logic TRIP,
   output logic NET_MODE,
   output logic FORCE_OP
);
   import term_pkg::*;

   code_arr_t func_r;
   logic [NUM_TERM-1:0] pol_r;
   logic [7:0] accel_r;
   logic [7:0] decel_r;
   logic [15:0] speed_r;
   logic prog_r;
   drive_state_t state_r;
   drive_state_t state_nxt;
   logic dir_r;
   logic hold_r;

   logic [NUM_TERM-1:0] t_lvl;
   logic [NUM_TERM-1:0] t_rise;
   logic [NUM_TERM-1:0] t_fall;
   logic [NUM_KEY-1:0] k_rise;

   logic start_in;
   logic stop_in;
   logic fwd_rise;
   logic fwd_fall;
   logic dir_in;
   logic up_in;
   logic down_in;
   logic network_select_in;
   logic force_operator_in;
   logic external_trip_in;
   logic thermistor_protect_in;
   logic local_term;
   logic start_req;
   logic stop_req;
   logic trip_req;
   logic dir_req;
   logic running;
   logic near_stop;
   logic [15:0] target;
   logic wr_ok;
   int sel_idx;

   ramp_if rif ();

   if (TICK < 1 || FULL == 16'h0000) begin : g_chk
      $error("term_map_top needs a nonzero tick and full scale");
   end

   // Terminal pins: synchronise, then apply polarity
   term_sense #(
      .N(NUM_TERM)
   ) u_term (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .pin(TERM_IN),
      .invert(pol_r),
      .level(t_lvl),
      .rise(t_rise),
      .fall(t_fall)
   );

   // Panel keys are pins as well, always active high
   term_sense #(
      .N(NUM_KEY)
   ) u_key (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .pin(KEY_IN),
      .invert('0),
      .level(),
      .rise(k_rise),
      .fall()
   );

   // Speed ramp shared by acceleration and deceleration
   ramp_gen #(
      .TICK(TICK),
      .FULL(FULL)
   ) u_ramp (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .rp(rif.gen)
   );

   // Function decode over all terminals
   assign start_in = fn_hit(func_r, t_rise, FN_START);
   assign stop_in = fn_hit(func_r, t_rise, FN_STOP);
   assign dir_in = fn_hit(func_r, t_lvl, FN_DIR);
   assign fwd_rise = fn_hit(func_r, t_rise, FN_FWD);
   assign fwd_fall = fn_hit(func_r, t_fall, FN_FWD);
   assign up_in = fn_hit(func_r, t_lvl, FN_UP);
   assign down_in = fn_hit(func_r, t_lvl, FN_DOWN);
   assign network_select_in = fn_hit(func_r, t_lvl, FN_NET);
   assign force_operator_in = fn_hit(func_r, t_lvl, FN_FORCE_OP);
   assign external_trip_in = fn_hit(func_r, t_lvl, FN_EXT);
   assign thermistor_protect_in = t_lvl[THERM_TERM]
      && (func_r[THERM_TERM] == FN_THERM);

   // Terminals command the motor only locally and when not overridden by the panel
   assign local_term = !network_select_in && !force_operator_in;

   // Run and stop sources; the network owns them while selected, apart from the stop key
   always_comb begin
      if (network_select_in) begin
         start_req = NET_RUN;
         stop_req = NET_STOP | k_rise[KEY_STOP];
         dir_req = NET_REV;
      end else begin
         start_req = (k_rise[KEY_RUN] && RUN_KEY_EN)
            || (local_term && (start_in || fwd_rise));
         stop_req = k_rise[KEY_STOP]
            || (local_term && (stop_in || fwd_fall));
         dir_req = local_term ? dir_in : dir_r;
      end
   end

   assign trip_req = external_trip_in || thermistor_protect_in;
   assign running = (state_r == DS_RUN);
   assign near_stop = (rif.freq <= NEAR_STOP);

   // Drive state; trip wins, then stop, then start
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DS_STOP: begin
            if (trip_req) begin
               state_nxt = DS_TRIP;
            end else if (start_req && !stop_req) begin
               state_nxt = DS_RUN;
            end
         end
         DS_RUN: begin
            if (trip_req) begin
               state_nxt = DS_TRIP;
            end else if (stop_req) begin
               state_nxt = DS_STOP;
            end
         end
         DS_TRIP: begin
            // Leaves trip only by a stop request after the cause is gone
            if (!trip_req && stop_req) begin
               state_nxt = DS_STOP;
            end
         end
         default: state_nxt = DS_STOP;
      endcase
   end

   // Run/stop state never looks at program mode
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_r <= DS_STOP;
      end else if (CE) begin
         state_r <= state_nxt;
      end
   end

   // Program/monitor state moved by panel keys only
   always_ff @(posedge CLK) begin
      if (RST) begin
         prog_r <= 1'b0;
      end else if (CE) begin
         if (k_rise[KEY_MON]) begin
            prog_r <= 1'b0;
         end else if (k_rise[KEY_PRG]) begin
            prog_r <= 1'b1;
         end
      end
   end

   // Direction turns over only near standstill, so reversal ramps through zero
   always_ff @(posedge CLK) begin
      if (RST) begin
         dir_r <= 1'b0;
      end else if (CE) begin
         if (dir_req != dir_r && near_stop) begin
            dir_r <= dir_req;
         end
      end
   end

   // Up/down pot: on release the reached speed becomes the new setpoint
   always_ff @(posedge CLK) begin
      if (RST) begin
         hold_r <= 1'b0;
      end else if (CE) begin
         hold_r <= local_term && (up_in || down_in);
      end
   end

   // Speed target chosen from the active control source
   always_comb begin
      if (!running || dir_req != dir_r) begin
         target = 16'h0000;
      end else if (network_select_in) begin
         target = (NET_SPEED > FULL) ? FULL : NET_SPEED;
      end else if (local_term && up_in) begin
         target = FULL;
      end else if (local_term && down_in) begin
         target = 16'h0000;
      end else begin
         target = (speed_r > FULL) ? FULL : speed_r;
      end
   end

   assign rif.target = target;
   assign rif.rate = (target > rif.freq) ? accel_r : decel_r;

   // Store port: write accepted only in program mode and with a legal value
   assign sel_idx = int'(PARAM_SEL);

   always_comb begin
      wr_ok = prog_r;
      if (PARAM_SEL < SEL_POL1) begin
         wr_ok = prog_r && !running && (PARAM_DATA[15:8] == 8'h00)
            && func_legal(PARAM_DATA[7:0], sel_idx);
      end else if (PARAM_SEL < SEL_ACCEL) begin
         wr_ok = prog_r && !running
            && (PARAM_DATA == {8'h00, POL_NO} || PARAM_DATA == {8'h00, POL_NC});
      end else if (PARAM_SEL == SEL_ACCEL || PARAM_SEL == SEL_DECEL) begin
         wr_ok = prog_r && !running && (PARAM_DATA[15:8] == 8'h00);
      end else if (PARAM_SEL != SEL_SPEED) begin
         wr_ok = 1'b0;
      end
   end

   // Function and polarity codes
   always_ff @(posedge CLK) begin
      if (RST) begin
         func_r[0] <= FUNC1_RST;
         func_r[1] <= FUNC2_RST;
         func_r[2] <= FUNC3_RST;
         pol_r <= {NUM_TERM{POL_RST[0]}};
      end else if (CE && STORE_STB && wr_ok) begin
         for (int i = 0; i < NUM_TERM; i++) begin
            if (PARAM_SEL == SEL_FUNC1 + 4'(i)) begin
               func_r[i] <= PARAM_DATA[7:0];
            end
            if (PARAM_SEL == SEL_POL1 + 4'(i)) begin
               pol_r[i] <= PARAM_DATA[0];
            end
         end
      end
   end

   // Ramp times
   always_ff @(posedge CLK) begin
      if (RST) begin
         accel_r <= RAMP_RST;
         decel_r <= RAMP_RST;
      end else if (CE && STORE_STB && wr_ok) begin
         if (PARAM_SEL == SEL_ACCEL) begin
            accel_r <= PARAM_DATA[7:0];
         end
         if (PARAM_SEL == SEL_DECEL) begin
            decel_r <= PARAM_DATA[7:0];
         end
      end
   end

   // Local setpoint; editable in program mode even while running
   always_ff @(posedge CLK) begin
      if (RST) begin
         speed_r <= SPEED_RST;
      end else if (CE) begin
         if (STORE_STB && wr_ok && PARAM_SEL == SEL_SPEED) begin
            speed_r <= PARAM_DATA;
         end else if (hold_r && !(local_term && (up_in || down_in))) begin
            speed_r <= rif.freq;
         end
      end
   end

   // Read-back of stored values and status
   always_ff @(posedge CLK) begin
      if (RST) begin
         PARAM_Q <= 16'h0000;
         STORE_REJ <= 1'b0;
      end else if (CE) begin
         STORE_REJ <= STORE_STB && !wr_ok;
         case (PARAM_SEL)
            SEL_FUNC1: PARAM_Q <= {8'h00, func_r[0]};
            SEL_FUNC1 + 4'h1: PARAM_Q <= {8'h00, func_r[1]};
            SEL_FUNC1 + 4'h2: PARAM_Q <= {8'h00, func_r[2]};
            SEL_POL1: PARAM_Q <= {15'h0000, pol_r[0]};
            SEL_POL1 + 4'h1: PARAM_Q <= {15'h0000, pol_r[1]};
            SEL_POL1 + 4'h2: PARAM_Q <= {15'h0000, pol_r[2]};
            SEL_ACCEL: PARAM_Q <= {8'h00, accel_r};
            SEL_DECEL: PARAM_Q <= {8'h00, decel_r};
            SEL_SPEED: PARAM_Q <= speed_r;
            SEL_STATUS: PARAM_Q <= {9'h000, t_lvl, state_r == DS_TRIP, dir_r, prog_r, running};
            default: PARAM_Q <= 16'h0000;
         endcase
      end
   end

   // Indicators and drive outputs, all registered
   always_ff @(posedge CLK) begin
      if (RST) begin
         RUN_LED <= 1'b0;
         PROG_LED <= 1'b0;
         DRIVE_ON <= 1'b0;
         FREQ_OUT <= 16'h0000;
         REVERSE <= 1'b0;
         TRIP <= 1'b0;
         NET_MODE <= 1'b0;
         FORCE_OP <= 1'b0;
      end else if (CE) begin
         RUN_LED <= running;
         PROG_LED <= prog_r;
         // Keeps driving through deceleration, drops at near stop; trip cuts at once
         DRIVE_ON <= (state_r != DS_TRIP) && (running || !near_stop)
            && !(target == 16'h0000 && near_stop);
         FREQ_OUT <= rif.freq;
         REVERSE <= dir_r;
         TRIP <= (state_r == DS_TRIP);
         NET_MODE <= network_select_in;
         FORCE_OP <= force_operator_in;
      end
   end
endmodule // term_map_top
`default_nettype wire

// ==== bench/term_map_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module term_map_checker
   import term_pkg::*;
#(
   parameter int TICK = 10,
   parameter logic [15:0] FULL = 16'h0258
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic STORE_STB,
   input wire logic [3:0] PARAM_SEL,
   input wire logic [15:0] PARAM_DATA,
   input wire logic STORE_REJ,
   input wire logic RUN_LED,
   input wire logic PROG_LED,
   input wire logic DRIVE_ON,
   input wire logic [15:0] FREQ_OUT,
   input wire logic REVERSE,
   input wire logic TRIP
);
   import term_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // Reset must leave every indicator and the drive dark
   AST_RESET_DARK: assert property (disable iff (1'b0) RST |=> !RUN_LED && !PROG_LED && !DRIVE_ON
      && FREQ_OUT == 16'h0000 && !TRIP) else $error("outputs not cleared by reset");
   AST_SEL9_REJ: assert property (CE && STORE_STB && PARAM_SEL == 4'h9 |=> STORE_REJ)
      else $error("status write not refused");
   AST_ANALOG_REJ: assert property (CE && STORE_STB && PARAM_SEL <= 4'h2
      && PARAM_DATA == 16'h0010 |=> STORE_REJ) else $error("analog select code accepted");
   AST_THERM_REJ: assert property (CE && STORE_STB && PARAM_SEL <= 4'h1
      && PARAM_DATA == 16'h0013 |=> STORE_REJ) else $error("thermistor code on terminal 1/2");
   // Ramp moves one 0.1 Hz step at most per cycle, or drops to zero on reset
   AST_RAMP_STEP: assert property (CE |=> FREQ_OUT == $past(FREQ_OUT)
      || FREQ_OUT == $past(FREQ_OUT) + 16'h0001 || FREQ_OUT + 16'h0001 == $past(FREQ_OUT)
      || FREQ_OUT == 16'h0000) else $error("ramp jumped");
   AST_FREQ_MAX: assert property (FREQ_OUT <= FULL) else $error("frequency above full scale");
   // Shutoff and the last frequency are registered on the same edge; a trip may cut at speed
   AST_STOP_OFF: assert property ($fell(DRIVE_ON) && !TRIP |-> FREQ_OUT <= NEAR_STOP)
      else $error("drive shut off at speed");
   // A zero setpoint may leave run lit with the drive dark, so only speed above near stop counts
   AST_RUN_DRIVE: assert property (RUN_LED && FREQ_OUT > NEAR_STOP |-> DRIVE_ON)
      else $error("running at speed without drive");
   AST_DIR_SLOW: assert property ($changed(REVERSE) |-> FREQ_OUT <= NEAR_STOP)
      else $error("direction flipped at speed");
   AST_TRIP_STOP: assert property (TRIP && $past(TRIP) |-> !RUN_LED)
      else $error("running while tripped");
endmodule // term_map_checker
bind term_map_top term_map_checker #(.TICK(TICK), .FULL(FULL)) u_chk (.CLK(CLK), .RST(RST),
   .CE(CE), .STORE_STB(STORE_STB), .PARAM_SEL(PARAM_SEL), .PARAM_DATA(PARAM_DATA),
   .STORE_REJ(STORE_REJ), .RUN_LED(RUN_LED), .PROG_LED(PROG_LED), .DRIVE_ON(DRIVE_ON),
   .FREQ_OUT(FREQ_OUT), .REVERSE(REVERSE), .TRIP(TRIP));
`default_nettype wire

// ==== bench/term_contacts.sv ====
`timescale 1ns/1ps
`default_nettype none
module term_contacts (
   input wire logic [2:0] closed,
   output logic [2:0] pin
);
   // Each contact closes onto the high supply; open reads low through a pull-down
   assign pin = closed;
endmodule // term_contacts
`default_nettype wire

// ==== bench/input_terminal_function_map_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module input_terminal_function_map_tb;
   import term_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [2:0] closed = 3'h0;
   logic [2:0] pin;
   logic [3:0] key = 4'h0;
   logic run_en = 1'b0;
   logic stb = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [15:0] data = 16'h0000;
   logic net_run = 1'b0;
   logic net_stop = 1'b0;
   logic [15:0] net_speed = 16'h0000;
   logic [15:0] param_q, freq;
   logic rej, run_led, prog_led, drive_on, reverse, trip, net_mode, force_op;
   int n_errors = 0;
   int checked = 0;
   int t;
   localparam logic [15:0] RST_TAB [8] = '{16'h0000, 16'h0015, 16'h000C, 16'h0000,
      16'h0000, 16'h0000, 16'h0064, 16'h0064};
   // Select, data, refused
   localparam logic [20:0] ST_TAB [15] = '{{4'h0, 16'h0010, 1'b1}, {4'h1, 16'h0013, 1'b1},
      {4'h0, 16'h0020, 1'b1}, {4'h0, 16'h0100, 1'b1}, {4'h3, 16'h0002, 1'b1},
      {4'h9, 16'h0000, 1'b1}, {4'h2, 16'h0013, 1'b0}, {4'h0, 16'h001B, 1'b0},
      {4'h1, 16'h001C, 1'b0}, {4'h2, 16'h0019, 1'b0}, {4'h2, 16'h001F, 1'b0},
      {4'h0, 16'h0014, 1'b0}, {4'h1, 16'h0015, 1'b0}, {4'h2, 16'h0016, 1'b0},
      {4'h8, 16'h003C, 1'b0}};

   // 100 ns clock
   always #50 clk = ~clk;

   term_contacts u_sw (.closed(closed), .pin(pin));

   // Short ramp tick keeps a full-scale ramp at 6000 cycles
   term_map_top #(.TICK(60)) u_dut (.CLK(clk), .RST(rst), .CE(ce), .TERM_IN(pin),
      .KEY_IN(key), .RUN_KEY_EN(run_en), .STORE_STB(stb), .PARAM_SEL(sel),
      .PARAM_DATA(data), .NET_RUN(net_run), .NET_STOP(net_stop), .NET_REV(1'b0),
      .NET_SPEED(net_speed), .PARAM_Q(param_q), .STORE_REJ(rej), .RUN_LED(run_led),
      .PROG_LED(prog_led), .DRIVE_ON(drive_on), .FREQ_OUT(freq), .REVERSE(reverse),
      .TRIP(trip), .NET_MODE(net_mode), .FORCE_OP(force_op));

   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_val({15'h0000, got}, {15'h0000, exp});
   endtask

   function automatic logic sig(input int w);
      case (w)
         0: return run_led;
         1: return prog_led;
         2: return drive_on;
         3: return net_mode;
         4: return force_op;
         5: return trip;
         default: return reverse;
      endcase
   endfunction

   // Bounded wait; a run-out shows as a mismatch and ends the run
   task automatic wait_sig(input int w, input logic v);
      t = 0;
      while (sig(w) !== v && t < 20000) begin
         @(posedge clk);
         #1;
         t++;
      end
      cmp_bit(sig(w), v);
      if (t >= 20000) test_done();
   endtask

   task automatic wait_freq(input logic [15:0] f);
      t = 0;
      while (freq !== f && t < 20000) begin
         @(posedge clk);
         #1;
         t++;
      end
      cmp_val(freq, f);
      if (t >= 20000) test_done();
   endtask

   task automatic store(input logic [3:0] s, input logic [15:0] d, input logic r);
      @(posedge clk);
      sel <= s;
      data <= d;
      stb <= 1'b1;
      @(posedge clk);
      stb <= 1'b0;
      #1;
      cmp_bit(rej, r);
      if (!r) begin
         @(posedge clk);
         #1;
         cmp_val(param_q, d);
      end
   endtask

   task automatic read_chk(input logic [3:0] s, input logic [15:0] e);
      @(posedge clk);
      sel <= s;
      repeat (2) @(posedge clk);
      #1;
      cmp_val(param_q, e);
   endtask

   // Keys are held long enough to clear the synchronisers
   task automatic press(input int k);
      @(posedge clk);
      key[k] <= 1'b1;
      repeat (6) @(posedge clk);
      key[k] <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic set_pin(input int k, input logic v);
      @(posedge clk);
      closed[k] <= v;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      cmp_bit(run_led | prog_led | drive_on | trip, 1'b0);
      for (int i = 0; i < 8; i++) read_chk(4'(i), RST_TAB[i]);
      store(4'h8, 16'h003C, 1'b1);
      press(KEY_PRG);
      wait_sig(1, 1'b1);
      for (int i = 0; i < 15; i++) store(ST_TAB[i][20:17], ST_TAB[i][16:1], ST_TAB[i][0]);
      press(KEY_MON);
      wait_sig(1, 1'b0);
      // Start input held: 60 steps of 10 cycles after a 5-cycle pipeline
      set_pin(0, 1'b1);
      wait_freq(16'h003C);
      cmp_bit((t > 560) && (t < 660), 1'b1);
      cmp_bit(run_led & drive_on, 1'b1);
      set_pin(0, 1'b0);
      press(KEY_PRG);
      wait_sig(1, 1'b1);
      cmp_bit(run_led, 1'b1);
      store(4'h0, 16'h0014, 1'b1);
      set_pin(2, 1'b1);
      wait_sig(6, 1'b1);
      set_pin(1, 1'b1);
      wait_sig(0, 1'b0);
      set_pin(1, 1'b0);
      wait_sig(2, 1'b0);
      cmp_bit(freq <= 16'h0005, 1'b1);
      set_pin(2, 1'b0);
      // Normally closed: the open contact now reads as a start
      store(4'h3, 16'h0001, 1'b0);
      wait_sig(0, 1'b1);
      press(KEY_STOP);
      wait_sig(0, 1'b0);
      wait_sig(2, 1'b0);
      // Polarity back to open first; an open NC contact on the up input would overwrite the setpoint
      store(4'h3, 16'h0000, 1'b0);
      store(4'h0, 16'h001B, 1'b0);
      store(4'h1, 16'h001C, 1'b0);
      press(KEY_RUN);
      cmp_bit(run_led, 1'b0);
      run_en <= 1'b1;
      press(KEY_RUN);
      wait_sig(0, 1'b1);
      wait_freq(16'h003C);
      set_pin(0, 1'b1);
      wait_freq(16'h0050);
      set_pin(0, 1'b0);
      set_pin(1, 1'b1);
      wait_freq(16'h0028);
      set_pin(1, 1'b0);
      press(KEY_STOP);
      wait_sig(2, 1'b0);
      store(4'h2, 16'h0019, 1'b0);
      set_pin(2, 1'b1);
      wait_sig(3, 1'b1);
      press(KEY_RUN);
      cmp_bit(run_led, 1'b0);
      net_speed <= 16'h003C;
      @(posedge clk);
      net_run <= 1'b1;
      @(posedge clk);
      net_run <= 1'b0;
      wait_sig(0, 1'b1);
      @(posedge clk);
      net_stop <= 1'b1;
      @(posedge clk);
      net_stop <= 1'b0;
      wait_sig(0, 1'b0);
      set_pin(2, 1'b0);
      wait_sig(3, 1'b0);
      wait_sig(2, 1'b0);
      store(4'h2, 16'h001F, 1'b0);
      set_pin(2, 1'b1);
      wait_sig(4, 1'b1);
      set_pin(2, 1'b0);
      wait_sig(4, 1'b0);
      store(4'h2, 16'h000C, 1'b0);
      set_pin(2, 1'b1);
      wait_sig(5, 1'b1);
      set_pin(2, 1'b0);
      press(KEY_STOP);
      wait_sig(5, 1'b0);
      // Thermistor input on terminal three trips like an external trip
      store(4'h2, 16'h0013, 1'b0);
      set_pin(2, 1'b1);
      wait_sig(5, 1'b1);
      set_pin(2, 1'b0);
      press(KEY_STOP);
      wait_sig(5, 1'b0);
      // Clock enable low freezes the synchronisers, so a key press is lost
      @(posedge clk);
      ce <= 1'b0;
      press(KEY_MON);
      @(posedge clk);
      ce <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      cmp_bit(prog_led, 1'b1);
      test_done();
   end
endmodule // input_terminal_function_map_tb
`default_nettype wire
